// ### hw/lbq_cycle_qual.sv
// Direction, size and transaction code pins of the local bus port
`timescale 1ns/100ps
`default_nettype none
`include "lbq_map.svh"
module lbq_cycle_qual #(
	// Lane count; the lane decode serves a 32-bit port only
	parameter int LANES_W = `LBQ_LANES_W,
	// Sync depth of the pin inputs; the logic is built for two
	parameter int SYNC_DEPTH = `LBQ_SYNC_DEPTH
) (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	// Master side request from the bridge core
	input wire logic mst_own_i,
	input wire logic mst_load_i,
	input wire lbq_pkg::lbq_qual_s mst_qual_i,
	input wire logic [1:0] mst_addr_lo_i,
	// Pins: direction, size, transaction code, start strobe
	input wire logic dir_i,
	output logic dir_o,
	output logic dir_oe_o,
	input wire logic [`LBQ_SIZE_W-1:0] transfer_size_code_i,
	output logic [`LBQ_SIZE_W-1:0] transfer_size_code_o,
	output logic transfer_size_code_oe_o,
	input wire logic [`LBQ_TC_W-1:0] transaction_code_bus_i,
	output logic [`LBQ_TC_W-1:0] transaction_code_bus_o,
	output logic transaction_code_bus_oe_o,
	input wire logic transfer_start_strobe_n_i,
	// Slave side results and master lanes
	output lbq_pkg::lbq_qual_s slv_qual_o,
	output logic slv_valid_o,
	output logic slv_burst_o,
	output logic [`LBQ_LANES_W-1:0] slv_lanes_o,
	output logic [`LBQ_LANES_W-1:0] mst_lanes_o
);
	import lbq_pkg::*;

	// Refuse settings the fixed logic cannot serve
	if (LANES_W != `LBQ_LANES_W) begin : g_lanes_chk
		$error("lane count other than four is not supported");
	end
	if (SYNC_DEPTH != `LBQ_SYNC_DEPTH) begin : g_sync_chk
		$error("pin synchroniser depth other than two is not supported");
	end

	// Byte lanes for a 32-bit port, lane 0 at the lowest address
	function automatic logic [`LBQ_LANES_W-1:0] lanes_f(
		input logic [`LBQ_SIZE_W-1:0] sz,
		input logic [`LBQ_ADDR_W-1:0] a
	);
		logic [`LBQ_LANES_W-1:0] l;
		l = `LBQ_LANES_NONE;
		case (sz)
			`LBQ_SIZE_1B: begin
				l = `LBQ_LANE_ONE << a;
			end
			`LBQ_SIZE_2B: begin
				l = a[1] ? `LBQ_LANES_HI_HALF : `LBQ_LANES_LO_HALF;
			end
			`LBQ_SIZE_4B: begin
				l = `LBQ_LANES_ALL;
			end
			default: begin
				// A line moves whole words, so every lane is on
				l = `LBQ_LANES_ALL;
			end
		endcase
		return l;
	endfunction : lanes_f

	// Pin synchronisers, two flops each
	lbq_qual_s pin_now;
	lbq_qual_s pin_s1_r;
	lbq_qual_s pin_s2_r;
	logic strobe_s1_r;
	logic strobe_s2_r;
	logic start_d_r;
	// Master side state
	lbq_role_e role_r;
	lbq_role_e role_nxt;
	logic own_r;
	lbq_qual_s mst_r;
	logic [`LBQ_LANES_W-1:0] mst_lanes_r;
	// Slave side state
	lbq_qual_s slv_r;
	logic valid_r;
	logic burst_r;
	logic [`LBQ_LANES_W-1:0] slv_lanes_r;

	// Named decodes
	wire strobe_now = ~transfer_start_strobe_n_i;
	wire is_slave = (role_r == LBQ_SLAVE);
	// Only the leading edge counts, so a strobe held low is taken once
	wire slv_take = strobe_s2_r & ~start_d_r & is_slave;
	wire slv_line = (pin_s2_r.size == `LBQ_SIZE_LINE);
	wire mst_line = (mst_qual_i.size == `LBQ_SIZE_LINE);
	// Reserved as master; fall back to four bytes rather than drive it
	wire [`LBQ_SIZE_W-1:0] mst_size = mst_line ? `LBQ_SIZE_4B : mst_qual_i.size;
	wire [`LBQ_LANES_W-1:0] mst_lanes_nxt = lanes_f(mst_size, mst_addr_lo_i);
	// The slave never sees the low address here, so lanes assume zero
	wire [`LBQ_LANES_W-1:0] slv_lanes_nxt = lanes_f(pin_s2_r.size, `LBQ_ADDR_ZERO);

	assign pin_now.dir = dir_i;
	assign pin_now.size = transfer_size_code_i;
	assign pin_now.tc = transaction_code_bus_i;

	// Role also keeps the first cycle after reset from taking a strobe
	always_comb begin
		role_nxt = role_r;
		case (role_r)
			LBQ_IDLE: begin
				role_nxt = mst_own_i ? LBQ_MASTER : LBQ_SLAVE;
			end
			LBQ_MASTER: begin
				role_nxt = mst_own_i ? LBQ_MASTER : LBQ_SLAVE;
			end
			LBQ_SLAVE: begin
				role_nxt = mst_own_i ? LBQ_MASTER : LBQ_SLAVE;
			end
			default: begin
				role_nxt = LBQ_IDLE;
			end
		endcase
	end

	// Data pins
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end else if (clk_en_i) begin
			pin_s1_r <= pin_now;
			pin_s2_r <= pin_s1_r;
		end
	end

	// Strobe and its delay; zero matches the idle high pin, so no false edge
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			strobe_s1_r <= 1'b0;
			strobe_s2_r <= 1'b0;
			start_d_r <= 1'b0;
		end else if (clk_en_i) begin
			strobe_s1_r <= strobe_now;
			strobe_s2_r <= strobe_s1_r;
			start_d_r <= strobe_s2_r;
		end
	end

	// Role and output enables
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			role_r <= LBQ_IDLE;
			own_r <= 1'b0;
		end else if (clk_en_i) begin
			role_r <= role_nxt;
			own_r <= mst_own_i;
		end
	end

	// Master qualifiers load with the address and hold until the next load
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			mst_r <= '0;
		end else if (clk_en_i && mst_load_i) begin
			mst_r.dir <= mst_qual_i.dir;
			mst_r.size <= mst_size;
			mst_r.tc <= mst_qual_i.tc;
		end
	end

	// Master lanes follow the same load
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			mst_lanes_r <= `LBQ_LANES_NONE;
		end else if (clk_en_i && mst_load_i) begin
			mst_lanes_r <= mst_lanes_nxt;
		end
	end

	// Slave valid pulse
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			valid_r <= 1'b0;
		end else if (clk_en_i) begin
			valid_r <= slv_take;
		end
	end

	// Slave qualifiers stand until the next strobe
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			slv_r <= '0;
			burst_r <= 1'b0;
		end else if (clk_en_i && slv_take) begin
			slv_r <= pin_s2_r;
			burst_r <= slv_line;
		end
	end

	// Slave lanes follow the same strobe
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			slv_lanes_r <= `LBQ_LANES_NONE;
		end else if (clk_en_i && slv_take) begin
			slv_lanes_r <= slv_lanes_nxt;
		end
	end

	// Pins: values and enables straight from flops
	assign dir_o = mst_r.dir;
	assign dir_oe_o = own_r;
	assign transfer_size_code_o = mst_r.size;
	assign transfer_size_code_oe_o = own_r;
	assign transaction_code_bus_o = mst_r.tc;
	assign transaction_code_bus_oe_o = own_r;

	// Slave results and master lanes
	assign slv_qual_o = slv_r;
	assign slv_valid_o = valid_r;
	assign slv_burst_o = burst_r;
	assign slv_lanes_o = slv_lanes_r;
	assign mst_lanes_o = mst_lanes_r;
endmodule : lbq_cycle_qual
`default_nettype wire

// ### hw/lbq_map.svh
// Constants for the local bus cycle qualifier block
`ifndef LBQ_MAP_SVH
`define LBQ_MAP_SVH
`define LBQ_SIZE_W 2
`define LBQ_TC_W 4
`define LBQ_SIZE_4B 2'h0
`define LBQ_SIZE_1B 2'h1
`define LBQ_SIZE_2B 2'h2
`define LBQ_SIZE_LINE 2'h3
`define LBQ_DIR_READ 1'h1
`define LBQ_DIR_WRITE 1'h0
`define LBQ_LANES_W 4
`define LBQ_ADDR_W 2
`define LBQ_ADDR_ZERO 2'h0
`define LBQ_SYNC_DEPTH 2
`define LBQ_LANES_NONE 4'h0
`define LBQ_LANE_ONE 4'h1
`define LBQ_LANES_LO_HALF 4'h3
`define LBQ_LANES_HI_HALF 4'hC
`define LBQ_LANES_ALL 4'hF
`endif

// ### hw/lbq_pkg.sv
// Types for the local bus cycle qualifier block
`include "lbq_map.svh"
package lbq_pkg;
	typedef struct packed {
		logic dir;
		logic [`LBQ_SIZE_W-1:0] size;
		logic [`LBQ_TC_W-1:0] tc;
	} lbq_qual_s;
	typedef enum logic [1:0] {
		LBQ_IDLE = 2'h0,
		LBQ_MASTER = 2'h1,
		LBQ_SLAVE = 2'h3
	} lbq_role_e;
endpackage : lbq_pkg

// ### test/lbq_cycle_qual_chk.sv
// Checker for the cycle qualifier pins
`timescale 1ns/100ps
`default_nettype none
module lbq_cycle_qual_chk (
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	// Inputs
	input wire logic mst_own_i,
	input wire logic mst_load_i,
	input wire lbq_pkg::lbq_qual_s mst_qual_i,
	input wire logic transfer_start_strobe_n_i,
	// Outputs
	input wire logic dir_o,
	input wire logic dir_oe_o,
	input wire logic [1:0] transfer_size_code_o,
	input wire logic transfer_size_code_oe_o,
	input wire logic [3:0] transaction_code_bus_o,
	input wire logic transaction_code_bus_oe_o,
	input wire lbq_pkg::lbq_qual_s slv_qual_o,
	input wire logic slv_valid_o,
	input wire logic slv_burst_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	a_oe_own: assert property ($past(resetn_i) && $past(clk_en_i) |->
		dir_oe_o == $past(mst_own_i) && transfer_size_code_oe_o == dir_oe_o &&
		transaction_code_bus_oe_o == dir_oe_o) else $error("oe lag");
	a_dir_load: assert property (clk_en_i && mst_load_i |=>
		dir_o == $past(mst_qual_i.dir)) else $error("dir");
	a_tc_load: assert property (clk_en_i && mst_load_i |=>
		transaction_code_bus_o == $past(mst_qual_i.tc)) else $error("tc");
	a_size_map: assert property (clk_en_i && mst_load_i |=> transfer_size_code_o ==
		($past(mst_qual_i.size) == 2'h3 ? 2'h0 : $past(mst_qual_i.size))) else $error("size");
	a_size_hold: assert property (!(clk_en_i && mst_load_i) |=>
		$stable(transfer_size_code_o)) else $error("hold");
	a_slv_lat: assert property ($fell(transfer_start_strobe_n_i) && clk_en_i
		##1 !mst_own_i && clk_en_i ##1 clk_en_i |-> ##1 slv_valid_o) else $error("latency");
	a_valid_once: assert property (slv_valid_o |=> !slv_valid_o) else $error("pulse");
	a_burst_flag: assert property (slv_valid_o |->
		slv_burst_o == (slv_qual_o.size == 2'h3)) else $error("burst");
	cover property (slv_valid_o && slv_burst_o);
	cover property (mst_load_i ##1 mst_load_i);
	cover property (dir_oe_o && dir_o);
endmodule : lbq_cycle_qual_chk
bind lbq_cycle_qual lbq_cycle_qual_chk u_chk (.*);
`default_nettype wire

// ### test/lbq_agent.sv
// Far side agent that starts cycles on the local bus
`timescale 1ns/100ps
`default_nettype none
module lbq_agent (
	input wire logic clk_i,
	output logic strobe_n_o,
	output logic dir_o,
	output logic [1:0] size_o,
	output logic [3:0] tc_o
);
	initial {strobe_n_o, dir_o, size_o, tc_o} = 8'hFF;
	task cycle(input logic d, input logic [1:0] s, input logic [3:0] t);
		@(posedge clk_i) #1;
		{strobe_n_o, dir_o, size_o, tc_o} = {1'b0, d, s, t};
		@(posedge clk_i) #1;
		strobe_n_o = 1'b1;
		{dir_o, size_o, tc_o} = ~{d, s, t};
	endtask : cycle
endmodule : lbq_agent
`default_nettype wire

// ### test/tb.sv
// Bench for the cycle qualifier block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import lbq_pkg::*;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic en = 1'b1;
	logic own = 1'b0;
	logic load = 1'b0;
	logic [1:0] al = 2'h0;
	logic a_d, d_d, d_oe, s_oe, t_oe, sn, sv, sb;
	logic [1:0] a_s, d_s;
	logic [3:0] a_t, d_t, sl, ml;
	lbq_qual_s mq = '0, sq;
	int errors = 0, checks = 0;
	initial forever #10 ref_clk_i = ~ref_clk_i;
	lbq_agent u_lbq_agent (.clk_i(ref_clk_i), .strobe_n_o(sn), .dir_o(a_d), .size_o(a_s), .tc_o(a_t));
	lbq_cycle_qual u_lbq_cycle_qual (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(en),
		.mst_own_i(own), .mst_load_i(load), .mst_qual_i(mq), .mst_addr_lo_i(al),
		.dir_i(d_oe ? d_d : a_d), .dir_o(d_d), .dir_oe_o(d_oe), .transfer_size_code_i(a_s),
		.transfer_size_code_o(d_s), .transfer_size_code_oe_o(s_oe), .transaction_code_bus_i(a_t),
		.transaction_code_bus_o(d_t), .transaction_code_bus_oe_o(t_oe),
		.transfer_start_strobe_n_i(sn), .slv_qual_o(sq), .slv_valid_o(sv), .slv_burst_o(sb),
		.slv_lanes_o(sl), .mst_lanes_o(ml));
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task stop_test;
		if (errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task mst_case(input logic d, input logic [1:0] s, input logic [3:0] t, input logic [1:0] a);
		logic [1:0] es;
		logic [3:0] el;
		es = (s == 2'h3) ? 2'h0 : s;
		el = 4'hF;
		if (es == 2'h1) el = 4'h1 << a;
		else if (es == 2'h2) el = a[1] ? 4'hC : 4'h3;
		mq = '{d, s, t};
		al = a;
		load = 1'b1;
		@(posedge ref_clk_i) #1;
		chk({1'h0, d_d, d_s, d_t}, {1'h0, d, es, t}, "master");
		chk({4'h0, ml}, {4'h0, el}, "master lanes");
		chk({5'h0, d_oe, s_oe, t_oe}, {5'h0, {3{own}}}, "enables");
	endtask : mst_case
	task freeze_case;
		logic [7:0] held;
		held = {1'h0, d_d, d_s, d_t};
		en = 1'b0;
		mq = ~mq;
		load = 1'b1;
		repeat (2) @(posedge ref_clk_i) #1;
		chk({1'h0, d_d, d_s, d_t}, held, "frozen");
		en = 1'b1;
		load = 1'b0;
		@(posedge ref_clk_i) #1;
	endtask : freeze_case
	task rst_case;
		resetn_i = 1'b0;
		repeat (2) @(posedge ref_clk_i) #1;
		chk({1'h0, d_oe, s_oe, t_oe, d_d, d_s, sv}, 8'h00, "reset outputs");
		resetn_i = 1'b1;
		repeat (2) @(posedge ref_clk_i) #1;
	endtask : rst_case
	task slv_case(input logic d, input logic [1:0] s, input logic [3:0] t);
		int n;
		logic [3:0] el;
		el = (s == 2'h1) ? 4'h1 : (s == 2'h2) ? 4'h3 : 4'hF;
		u_lbq_agent.cycle(d, s, t);
		for (n = 0; sv !== 1'b1 && n < 8; n++) @(posedge ref_clk_i) #1;
		if (n == 8) begin
			errors++;
			stop_test;
		end
		chk({sq, sb}, {d, s, t, s == 2'h3}, "slave");
		chk({4'h0, sl}, {4'h0, el}, "slave lanes");
	endtask : slv_case
	task refuse_case;
		logic seen;
		seen = 1'b0;
		own = 1'b1;
		repeat (2) @(posedge ref_clk_i) #1;
		u_lbq_agent.cycle(1'b1, 2'h1, 4'h3);
		repeat (4) begin
			seen = seen | sv;
			@(posedge ref_clk_i) #1;
		end
		chk({7'h0, seen}, 8'h00, "slave while master");
		own = 1'b0;
		repeat (2) @(posedge ref_clk_i) #1;
	endtask : refuse_case
	initial begin
		repeat (2) @(posedge ref_clk_i);
		#1 resetn_i = 1'b1;
		own = 1'b1;
		@(posedge ref_clk_i) #1;
		for (int i = 0; i < 8; i++) mst_case(i[0], i[1:0], 4'hA ^ i[3:0], i[2:1]);
		load = 1'b0;
		freeze_case;
		rst_case;
		own = 1'b0;
		repeat (2) @(posedge ref_clk_i) #1;
		for (int i = 0; i < 4; i++) slv_case(~i[0], i[1:0], 4'h5 ^ i[3:0]);
		refuse_case;
		chk({5'h0, d_oe, s_oe, t_oe}, 8'h0, "released");
		stop_test;
	end
endmodule : tb
`default_nettype wire
